// ==== rtl/ssc_clock_select.sv ====
// system clock source selector with output prescaler and glitch-free switching
`timescale 1ns/100ps
module ssc_clock_select (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_rst,
    input  wire logic                           i_direct_clock_input,
    input  wire logic                           i_crystal_input,
    input  wire logic                           i_internal_clock,
    input  wire logic                           i_wakeup_clock,
    input  wire logic                           i_loop_clock,
    input  wire logic [1:0]                     i_clock_source_select,
    input  wire logic                           i_vco_bypass_setting,
    input  wire logic                           i_prescaler_use_internal,
    input  wire logic [ssc_pkg::SSC_DIV_W-1:0]  i_prescaler_divider_field,
    output logic                                o_sys_clk,
    output logic                                o_loop_enable,
    output logic                                o_switch_busy
);
    import ssc_pkg::*;

    // elaboration-time guards: the counter must reach exactly the largest factor, and the loop source index must fit the synchroniser
    if (SSC_MAX_FACTOR != (1 << SSC_DIV_W)) begin
        $error("divider width cannot reach the largest factor");
    end
    if (SSC_SRC_LOOP >= SSC_NSRC) begin
        $error("source index outside the synchroniser");
    end

    ssc_state_s s_r;
    ssc_state_s s_nxt;

    // level of the clock that feeds the prescaler
    function automatic logic pick_prescale_src(input logic [SSC_NSRC-1:0] lv, input logic use_int);
        logic v;
        v = use_int ? lv[SSC_SRC_INTERNAL] : lv[SSC_SRC_CRYSTAL];
        return v;
    endfunction

    // picks the synchronised level of the source a configuration follows
    function automatic logic pick_src(input logic [SSC_NSRC-1:0] lv, input logic [1:0] sel,
                                      input logic byp, input logic use_int);
        logic v;
        v = 1'b0;
        case (sel)
            SSC_SEL_DIRECT: v = lv[SSC_SRC_DIRECT];
            SSC_SEL_WAKEUP: v = lv[SSC_SRC_WAKEUP];
            SSC_SEL_LOOP: begin
                if (byp) begin
                    v = pick_prescale_src(lv, use_int);
                end else begin
                    v = lv[SSC_SRC_LOOP];
                end
            end
            // reserved code gives no clock at all
            default:        v = 1'b0;
        endcase
        return v;
    endfunction

    // prescaler mode: loop select with the bypass set
    function automatic logic is_prescale(input logic [1:0] sel, input logic byp);
        return (sel == SSC_SEL_LOOP) && byp;
    endfunction

    // loop mode: loop select with the bypass clear
    function automatic logic is_loop(input logic [1:0] sel, input logic byp);
        return (sel == SSC_SEL_LOOP) && !byp;
    endfunction

    // any difference between the pins and the configuration in force
    function automatic logic cfg_differs(input ssc_state_s s, input logic [1:0] sel, input logic byp,
                                         input logic use_int, input logic [SSC_DIV_W-1:0] div);
        return (sel != s.sel) || (byp != s.bypass) || (use_int != s.use_internal) || (div != s.div);
    endfunction

    // either edge of the chosen source counts towards the factor
    function automatic logic src_edge(input logic now, input logic prev);
        return now != prev;
    endfunction

    // last source edge of one output half period
    function automatic logic half_done(input logic [SSC_DIV_W-1:0] cnt, input logic [SSC_DIV_W-1:0] div);
        return cnt == div;
    endfunction

    logic                cfg_change;
    logic                src_now;
    logic                prescale;
    logic [SSC_NSRC-1:0] pin_levels;

    always_comb begin
        s_nxt = s_r;
        // source pins are asynchronous to the reference clock
        pin_levels  = {i_loop_clock, i_internal_clock, i_crystal_input, i_direct_clock_input, i_wakeup_clock};
        s_nxt.sync1 = pin_levels;
        s_nxt.sync2 = s_r.sync1;
        src_now     = pick_src(s_r.sync2, s_r.sel, s_r.bypass, s_r.use_internal);
        prescale    = is_prescale(s_r.sel, s_r.bypass);
        cfg_change  = cfg_differs(s_r, i_clock_source_select, i_vco_bypass_setting,
                                  i_prescaler_use_internal, i_prescaler_divider_field);
        s_nxt.src_prev = src_now;
        s_nxt.loop_en  = is_loop(s_r.sel, s_r.bypass);
        case (s_r.state)
            SSC_RUN: begin
                if (prescale) begin
                    // toggling every factor edges gives factor periods, 50 percent duty
                    if (src_edge(src_now, s_r.src_prev)) begin
                        if (half_done(s_r.cnt, s_r.div)) begin
                            s_nxt.cnt     = '0;
                            s_nxt.clk_out = ~s_r.clk_out;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 1'b1;
                        end
                    end
                    // factor one follows the source level, duty included
                    if (s_r.div == '0) begin
                        s_nxt.clk_out = src_now;
                    end
                end else begin
                    s_nxt.clk_out = src_now;
                end
                if (cfg_change) begin
                    s_nxt.state = SSC_PARK;
                    s_nxt.busy  = 1'b1;
                end
            end
            SSC_PARK: begin
                // finish the present high phase so no runt pulse appears
                if (prescale && s_r.div != '0) begin
                    if (src_edge(src_now, s_r.src_prev) && s_r.clk_out) begin
                        if (half_done(s_r.cnt, s_r.div)) begin
                            s_nxt.cnt     = '0;
                            s_nxt.clk_out = 1'b0;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 1'b1;
                        end
                    end
                end else if (!src_now) begin
                    s_nxt.clk_out = 1'b0;
                end
                if (!s_r.clk_out) begin
                    s_nxt.clk_out      = 1'b0;
                    s_nxt.sel          = i_clock_source_select;
                    s_nxt.bypass       = i_vco_bypass_setting;
                    s_nxt.use_internal = i_prescaler_use_internal;
                    s_nxt.div          = i_prescaler_divider_field;
                    s_nxt.cnt          = '0;
                    s_nxt.state        = SSC_ALIGN;
                end
            end
            SSC_ALIGN: begin
                // start the new clock only from a low phase of its source
                s_nxt.clk_out = 1'b0;
                s_nxt.cnt     = '0;
                // a late change is taken first, so busy never drops on a stale setting
                if (cfg_change) begin
                    s_nxt.state = SSC_PARK;
                end else if (!src_now && s_r.sel != SSC_SEL_RESERVED) begin
                    s_nxt.state = SSC_RUN;
                    s_nxt.busy  = 1'b0;
                end
            end
            default: begin
                s_nxt.state = SSC_PARK;
                s_nxt.busy  = 1'b1;
            end
        endcase
        if (i_rst) begin
            s_nxt              = '0;
            // synchroniser keeps tracking the pins, so the first low seen after reset is real
            s_nxt.sync1        = pin_levels;
            s_nxt.sync2        = s_r.sync1;
            s_nxt.sel          = SSC_RST_SEL;
            s_nxt.div          = SSC_RST_DIV;
            s_nxt.state        = SSC_ALIGN;
            s_nxt.busy         = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s_r <= s_nxt;
    end

    assign o_sys_clk     = s_r.clk_out;
    assign o_loop_enable = s_r.loop_en;
    assign o_switch_busy = s_r.busy;
endmodule

// ==== rtl/ssc_pkg.sv ====
// constants and types for the system clock source selector
// Notes on behaviour
// - select code 11 drives system clock straight from the direct clock input
// - select code 10 with bypass 1 divides the oscillator clock in the prescaler
// - prescaler source is crystal or internal clock; factor is divider field plus one
// - factor one passes the oscillator clock through with its own duty cycle
// - prescaler reaches a largest factor of 1024
// - prescaler on crystal with factor one behaves like direct drive
// - select code 10 with bypass 0 enables the loop and uses its output
// - select code 00 takes the wakeup clock undivided
package ssc_pkg;
    localparam logic [1:0] SSC_SEL_WAKEUP   = 2'h0;
    localparam logic [1:0] SSC_SEL_RESERVED = 2'h1;
    localparam logic [1:0] SSC_SEL_LOOP     = 2'h2;
    localparam logic [1:0] SSC_SEL_DIRECT   = 2'h3;
    localparam int         SSC_DIV_W        = 10;
    localparam int         SSC_MAX_FACTOR   = 1024;
    localparam logic [1:0] SSC_RST_SEL      = SSC_SEL_WAKEUP;
    localparam logic [SSC_DIV_W-1:0] SSC_RST_DIV = 10'h000;
    localparam int         SSC_NSRC         = 5;
    localparam int         SSC_SRC_WAKEUP   = 0;
    localparam int         SSC_SRC_DIRECT   = 1;
    localparam int         SSC_SRC_CRYSTAL  = 2;
    localparam int         SSC_SRC_INTERNAL = 3;
    localparam int         SSC_SRC_LOOP     = 4;

    typedef enum logic [1:0] {
        SSC_RUN   = 2'b00,
        SSC_PARK  = 2'b01,
        SSC_ALIGN = 2'b10
    } ssc_state_e;

    typedef struct packed {
        logic [SSC_NSRC-1:0]  sync1;
        logic [SSC_NSRC-1:0]  sync2;
        logic                 src_prev;
        logic [1:0]           sel;
        logic                 bypass;
        logic                 use_internal;
        logic [SSC_DIV_W-1:0] div;
        logic [SSC_DIV_W-1:0] cnt;
        logic                 clk_out;
        logic                 loop_en;
        logic                 busy;
        ssc_state_e           state;
    } ssc_state_s;
endpackage

// ==== sim/ssc_checker.sv ====
// assertions on the clock selector ports
`timescale 1ns/100ps
module ssc_checker (
    input wire logic                         i_ref_clk,
    input wire logic                         i_rst,
    input wire logic                         i_direct_clock_input,
    input wire logic                         i_crystal_input,
    input wire logic                         i_internal_clock,
    input wire logic                         i_wakeup_clock,
    input wire logic                         i_loop_clock,
    input wire logic [1:0]                   i_clock_source_select,
    input wire logic                         i_vco_bypass_setting,
    input wire logic                         i_prescaler_use_internal,
    input wire logic [ssc_pkg::SSC_DIV_W-1:0] i_prescaler_divider_field,
    input wire logic                         o_sys_clk,
    input wire logic                         o_loop_enable,
    input wire logic                         o_switch_busy
);
    import ssc_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    chk_reset_clk_low: assert property ($fell(i_rst) |-> o_switch_busy && !o_sys_clk && !o_loop_enable)
        else $error("outputs wrong after reset");
    chk_sel_change_busy: assert property (!o_switch_busy && $changed(i_clock_source_select) |=> o_switch_busy)
        else $error("select change not seen");
    chk_div_change_busy: assert property (!o_switch_busy && $changed(i_prescaler_divider_field) |=> o_switch_busy)
        else $error("divider change not seen");
    chk_reserved_busy: assert property (i_clock_source_select == 2'h1 |=> o_switch_busy)
        else $error("reserved select not parked");
    chk_loop_mode: assert property (o_loop_enable && !o_switch_busy |->
        $past(i_clock_source_select) == 2'h2 && !$past(i_vco_bypass_setting))
        else $error("loop enabled outside loop mode");
    chk_hold_low: assert property (o_switch_busy && !o_sys_clk |=> !o_sys_clk || !o_switch_busy)
        else $error("clock rose during switch");
    chk_no_runt: assert property ($rose(o_sys_clk) |=> o_sys_clk)
        else $error("runt high pulse");
    chk_no_runt_low: assert property ($fell(o_sys_clk) |=> !o_sys_clk)
        else $error("runt low pulse");
    cov_loop: cover property (o_loop_enable && $rose(o_sys_clk));
    cov_switch: cover property ($fell(o_switch_busy));
    cov_direct: cover property (i_clock_source_select == 2'h3 && $rose(o_sys_clk));
endmodule
bind ssc_clock_select ssc_checker i_ssc_checker (.*);

// ==== sim/tb_system_clock_source_select.sv ====
// self-checking bench for the clock selector
`timescale 1ns/100ps
module tb_system_clock_source_select;
    import ssc_pkg::*;
    logic clk = 0, rst = 1, di = 0, xt = 0, it = 0, wu = 0, lp = 0, byp = 0, ui = 0, sc, lo, bz;
    logic [1:0] sel = 2'h0;
    logic [SSC_DIV_W-1:0] div = 10'h000;
    int cnt = 0, bad_count = 0, samples_checked = 0;
    ssc_clock_select i_ssc_clock_select (.i_ref_clk(clk), .i_rst(rst), .i_direct_clock_input(di),
        .i_crystal_input(xt), .i_internal_clock(it), .i_wakeup_clock(wu), .i_loop_clock(lp),
        .i_clock_source_select(sel), .i_vco_bypass_setting(byp), .i_prescaler_use_internal(ui),
        .i_prescaler_divider_field(div), .o_sys_clk(sc), .o_loop_enable(lo), .o_switch_busy(bz));
    initial begin
        forever #5 clk = ~clk;
    end
    // slow sources keep every level at least three samples wide
    always @(negedge clk) begin
        cnt <= cnt + 1;
        {di, xt, it, wu, lp} <= {1'((cnt/5)%2), 1'((cnt/4)%2), 1'((cnt/6)%2), 1'((cnt/7)%2), 1'((cnt/3)%2)};
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic final_report;
        $display("checked=%0d errors=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rise(output int t);
        logic p;
        t = 0;
        do begin
            p = sc;
            @(negedge clk);
            t++;
        end while (!(sc === 1'b1 && p === 1'b0) && t < 20000);
    endtask
    // switch, wait out the handover, then time one output period
    task automatic run(input logic [1:0] s, input logic b, input logic u, input logic [9:0] d, input int per,
                       input logic le);
        int n;
        @(negedge clk);
        {sel, byp, ui, div} = {s, b, u, d};
        repeat (3) @(negedge clk);
        n = 0;
        while (bz !== 1'b0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        rise(n);
        rise(n);
        check(n, per);
        n = 0;
        while (sc === 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check(n, per / 2);
        check(lo, le);
    endtask
    task automatic t_reserved;
        @(negedge clk);
        sel = 2'h1;
        repeat (60) @(negedge clk);
        check({sc, bz}, 2'b01);
    endtask
    task automatic t_wakeup;
        run(2'h0, 1'b0, 1'b0, 10'h000, 14, 1'b0);
    endtask
    task automatic t_direct;
        run(2'h3, 1'b0, 1'b0, 10'h000, 10, 1'b0);
    endtask
    task automatic t_pass;
        run(2'h2, 1'b1, 1'b0, 10'h000, 8, 1'b0);
    endtask
    task automatic t_divide;
        run(2'h2, 1'b1, 1'b0, 10'h002, 24, 1'b0);
    endtask
    task automatic t_internal;
        run(2'h2, 1'b1, 1'b1, 10'h003, 48, 1'b0);
    endtask
    task automatic t_loop;
        run(2'h2, 1'b0, 1'b0, 10'h003, 6, 1'b1);
    endtask
    // reset in mid-run: outputs park, then the wakeup default resumes
    task automatic t_reset_mid;
        @(negedge clk);
        rst = 1;
        {sel, byp, ui, div} = '0;
        repeat (2) @(negedge clk);
        check({sc, lo, bz}, 3'b001);
        rst = 0;
        @(negedge clk);
        check({sc, lo}, 2'b00);
        run(2'h0, 1'b0, 1'b0, 10'h000, 14, 1'b0);
    endtask
    task automatic t_max;
        run(2'h2, 1'b1, 1'b0, 10'h3ff, 8192, 1'b0);
    endtask
    // direct drive ignores the divider; crystal at factor one follows its source alike
    task automatic t_equiv;
        run(2'h3, 1'b0, 1'b0, 10'h3ff, 10, 1'b0);
        run(2'h2, 1'b1, 1'b0, 10'h000, 8, 1'b0);
    endtask
    initial begin
        #500000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (4) @(negedge clk);
        check({sc, lo, bz}, 3'b001);
        rst = 0;
        @(negedge clk);
        check({sc, lo, bz}, 3'b000);
        t_wakeup();
        t_direct();
        t_pass();
        t_divide();
        t_internal();
        t_loop();
        t_reset_mid();
        t_reserved();
        t_max();
        t_equiv();
        final_report();
    end
endmodule
